// ### design/aam_regs.svh
// Constants for the amplifier alarm monitor: clock rate, persistence times and condition indices.
`ifndef AAM_REGS_SVH
`define AAM_REGS_SVH
`define AAM_CLK_HZ       20000000
`define AAM_PERSIST_S    5
`define AAM_DCSHUT_S     1
`define AAM_LOOP_S       30
`define AAM_NUM_COND     11
`define AAM_C_GAINA      0
`define AAM_C_GAINB      1
`define AAM_C_TEMPW      2
`define AAM_C_SUPW       3
`define AAM_C_DCW        4
`define AAM_C_TEMPS      5
`define AAM_C_HVS        6
`define AAM_C_V9S        7
`define AAM_C_DCS        8
`define AAM_C_LOOP1      9
`define AAM_C_LOOP2      10
`endif

// ### design/aam_pkg.sv
// Types shared by the amplifier alarm monitor modules.
package aam_pkg;
  typedef logic signed [15:0] aam_meas_w_t;

  typedef struct packed {
    aam_meas_w_t inPwr;
    aam_meas_w_t outputRfPower;
    aam_meas_w_t loop1Err;
    aam_meas_w_t loop2Err;
    aam_meas_w_t tempInt;
    aam_meas_w_t tempBase;
    aam_meas_w_t v15;
    aam_meas_w_t v5;
    aam_meas_w_t vNeg5;
    aam_meas_w_t vHigh;
    aam_meas_w_t v9;
    aam_meas_w_t dcPwr;
    aam_meas_w_t mainAttSetting;
    aam_meas_w_t errAttSetting;
    aam_meas_w_t mainAttDefault;
    aam_meas_w_t errAttDefault;
  } aam_meas_t;

  typedef struct packed {
    logic enable;
    logic clearAlarms;
    logic disableAmp;
    logic statusSent;
  } aam_cmd_t;

  typedef struct packed {
    logic gain;
    logic partFail;
    logic tempWarn;
    logic supplyWarn;
    logic dcWarn;
    logic loop1;
    logic loop2;
  } aam_minor_t;

  typedef struct packed {
    logic tempShut;
    logic supplyShut;
    logic dcShut;
  } aam_major_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        hit;
  } aam_pers_st_t;

  typedef enum logic {ATT_IDLE, ATT_MON} aam_attst_t;

  typedef struct packed {
    aam_attst_t  st;
    aam_meas_w_t baseMain;
    aam_meas_w_t baseErr;
    logic        fail;
  } aam_att_st_t;

  typedef struct packed {
    aam_meas_t  meas;
    aam_minor_t minor;
    aam_major_t major;
    logic       ampOn;
    logic       mainOn;
    logic       errOn;
    logic       standby;
    logic       loop1Init;
    logic       loop2Init;
  } aam_top_st_t;
endpackage

// ### design/aam_persist.sv
// Persistence timer: output rises after the condition has held for COUNT uninterrupted cycles.
module aam_persist #(
  parameter int unsigned COUNT = 100000000
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic srst,
  // Condition and qualified result.
  input  wire logic cond,
  output logic      hit
);
  import aam_pkg::*;

  localparam logic [31:0] LAST = 32'(COUNT - 1);

  aam_pers_st_t st_r;
  aam_pers_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!cond) begin
      st_nxt.cnt = 32'h0; // RULE20
      st_nxt.hit = 1'b0;
    end else if (st_r.cnt < LAST) begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end else begin
      st_nxt.hit = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hit = st_r.hit;

  a_persist_restart: assert property (@(posedge clock) disable iff (srst) !cond |=> (!hit && st_r.cnt == 32'h0)) // RULE20
    else $error("persistence timer did not restart");
  a_persist_cause: assert property (@(posedge clock) disable iff (srst) $rose(hit) |-> $past(cond) && $past(st_r.cnt) == LAST)
    else $error("persistence output rose early");
endmodule

// ### design/aam_att_check.sv
// Attenuator drop check for partial amplifier failure: initial test against defaults, then tracking.
module aam_att_check #(
  parameter int unsigned MARGIN = 16
) (
  // Clock and reset.
  input  wire logic                clock,
  input  wire logic                srst,
  // Amplifiers on and loops converged.
  input  wire logic                active,
  // Attenuator settings and temperature-compensated defaults.
  input  wire aam_pkg::aam_meas_w_t mainAttSetting,
  input  wire aam_pkg::aam_meas_w_t errAttSetting,
  input  wire aam_pkg::aam_meas_w_t mainAttDefault,
  input  wire aam_pkg::aam_meas_w_t errAttDefault,
  // Failure level.
  output logic                     fail
);
  import aam_pkg::*;

  localparam logic signed [16:0] MRG = 17'(MARGIN);

  aam_att_st_t st_r;
  aam_att_st_t st_nxt;

  function automatic logic below(input aam_meas_w_t val, input aam_meas_w_t ref_v);
    below = (17'(val) + MRG) < 17'(ref_v);
  endfunction

  always_comb begin
    st_nxt = st_r;
    unique case (st_r.st)
      ATT_IDLE: begin
        st_nxt.fail = 1'b0;
        if (active) begin
          st_nxt.fail     = below(mainAttSetting, mainAttDefault) || below(errAttSetting, errAttDefault); // RULE4
          st_nxt.baseMain = mainAttSetting;
          st_nxt.baseErr  = errAttSetting;
          st_nxt.st       = ATT_MON;
        end
      end
      ATT_MON: begin
        if (!active) begin
          st_nxt.fail = 1'b0;
          st_nxt.st   = ATT_IDLE;
        end else begin
          st_nxt.fail = below(mainAttSetting, st_r.baseMain) || below(errAttSetting, st_r.baseErr); // RULE5
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '{st: ATT_IDLE, baseMain: '0, baseErr: '0, fail: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fail = st_r.fail;

  a_att_first: assert property (@(posedge clock) disable iff (srst)
    (st_r.st == ATT_IDLE && active && below(mainAttSetting, mainAttDefault)) |=> fail) // RULE4
    else $error("initial attenuator comparison missed");
  a_att_drop: assert property (@(posedge clock) disable iff (srst)
    (st_r.st == ATT_MON && active && below(errAttSetting, st_r.baseErr)) |=> fail) // RULE5
    else $error("attenuator drop not flagged");
  a_att_idle: assert property (@(posedge clock) disable iff (srst) !active |=> !fail)
    else $error("failure flagged while inactive");
endmodule

// ### design/aam_monitor.sv
// Amplifier alarm monitor top: thresholds, persistence, minor and major latches, standby control.
// Functional notes
// RULE1 - Pilot loss with error amplifier on raises error loop alarm immediately.
// RULE2 - Gain alarm when input above -3.8 dBm and output below 25 dBm for 5 s.
// RULE3 - Gain alarm when input above +2.5 dB for five seconds.
// RULE4 - On first convergence compare attenuators with defaults; lower sets partial failure.
// RULE5 - Afterwards a significant attenuator drop sets partial failure at once.
// RULE6 - Internal temperature above parameter threshold for 5 s sets minor warning.
// RULE7 - Any 15V, 5V, -5V rail outside ten percent for 5 s sets supply warning.
// RULE8 - DC power above 375W mode 1 or 300W mode 2 for 5 s warns.
// RULE9 - Major alarms latch and are not cleared by sending status.
// RULE10 - Enable, clear-alarms or disable clears all major alarms.
// RULE11 - Any major alarm forces standby with main and error amplifiers off.
// RULE12 - Base plate above threshold for 5 s latches over-temperature shutdown.
// RULE13 - High rail outside its mode window for 5 s latches supply shutdown.
// RULE14 - 9V rail above 9.9V or below 8.1V for 5 s latches supply shutdown.
// RULE15 - DC power above 417W mode 1 or 330W mode 2 for 1 s shuts down.
// RULE16 - First loop error above 2.5V for 30 s; no persistence at first enable.
// RULE17 - Second loop error above 2000 for 30 s; no persistence at first enable.
// RULE18 - After status is sent, minor alarms clear unless their condition remains.
// RULE19 - Enable, clear-alarms or disable clears all minor alarms.
// RULE20 - Persistence timers restart whenever their condition drops.
// RULE21 - Thresholds and times are parameters; measurements are registered each clock.
`include "aam_regs.svh"

module aam_monitor #(
  parameter int unsigned          PERSIST_CYC  = `AAM_PERSIST_S * `AAM_CLK_HZ,
  parameter int unsigned          DCSHUT_CYC   = `AAM_DCSHUT_S * `AAM_CLK_HZ,
  parameter int unsigned          LOOP_CYC     = `AAM_LOOP_S * `AAM_CLK_HZ,
  parameter aam_pkg::aam_meas_w_t IN_NOM_TH    = -16'sd38,
  parameter aam_pkg::aam_meas_w_t OUT_LOW_TH   = 16'sd250,
  parameter aam_pkg::aam_meas_w_t IN_HIGH_TH   = 16'sd25,
  parameter aam_pkg::aam_meas_w_t TEMP_WARN_TH = 16'sd90,
  parameter aam_pkg::aam_meas_w_t TEMP_SHUT_TH = 16'sd95,
  parameter aam_pkg::aam_meas_w_t V15_MIN      = 16'sd13500,
  parameter aam_pkg::aam_meas_w_t V15_MAX      = 16'sd16500,
  parameter aam_pkg::aam_meas_w_t V5_MIN       = 16'sd4500,
  parameter aam_pkg::aam_meas_w_t V5_MAX       = 16'sd5500,
  parameter aam_pkg::aam_meas_w_t VN5_MIN      = -16'sd5500,
  parameter aam_pkg::aam_meas_w_t VN5_MAX      = -16'sd4500,
  parameter aam_pkg::aam_meas_w_t VHI1_MIN     = 16'sd24800,
  parameter aam_pkg::aam_meas_w_t VHI1_MAX     = 16'sd30800,
  parameter aam_pkg::aam_meas_w_t VHI2_MIN     = 16'sd20250,
  parameter aam_pkg::aam_meas_w_t VHI2_MAX     = 16'sd25750,
  parameter aam_pkg::aam_meas_w_t V9_MIN       = 16'sd8100,
  parameter aam_pkg::aam_meas_w_t V9_MAX       = 16'sd9900,
  parameter aam_pkg::aam_meas_w_t DCW_M1       = 16'sd375,
  parameter aam_pkg::aam_meas_w_t DCW_M2       = 16'sd300,
  parameter aam_pkg::aam_meas_w_t DCS_M1       = 16'sd417,
  parameter aam_pkg::aam_meas_w_t DCS_M2       = 16'sd330,
  parameter aam_pkg::aam_meas_w_t LOOP1_TH     = 16'sd2500,
  parameter aam_pkg::aam_meas_w_t LOOP2_TH     = 16'sd2000,
  parameter int unsigned          ATT_MARGIN   = 16
) (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               srst,
  // Digitised measurements and operating mode (low is mode 1).
  input  wire aam_pkg::aam_meas_t meas,
  input  wire logic               mode2,
  // Loop controller status.
  input  wire logic               loopsConverged,
  input  wire logic               pilotLost,
  // Host station commands, one-cycle pulses.
  input  wire aam_pkg::aam_cmd_t  cmd,
  // Alarm status.
  output aam_pkg::aam_minor_t     minorAlarms,
  output aam_pkg::aam_major_t     majorAlarms,
  // Amplifier control.
  output logic                    mainAmpOn,
  output logic                    errAmpOn,
  output logic                    standby
);
  import aam_pkg::*;

  localparam int unsigned NC = `AAM_NUM_COND;
  localparam int unsigned PCNT [NC] = '{PERSIST_CYC, PERSIST_CYC, PERSIST_CYC, PERSIST_CYC, PERSIST_CYC,
                                        PERSIST_CYC, PERSIST_CYC, PERSIST_CYC, DCSHUT_CYC, LOOP_CYC, LOOP_CYC};

  aam_top_st_t st_r;
  aam_top_st_t st_nxt;
  logic [NC-1:0] cond;
  logic [NC-1:0] hit;
  logic          attFail;
  logic          loop1Above;
  logic          loop2Above;
  logic          clrAll;
  aam_minor_t    minCond;
  aam_major_t    majCond;

  function automatic logic outside(input aam_meas_w_t v, input aam_meas_w_t lo, input aam_meas_w_t hi);
    outside = (v < lo) || (v > hi);
  endfunction

  // ==========================================================================
  // Threshold comparisons on the registered measurements.
  // ==========================================================================
  always_comb begin
    cond = '0;
    cond[`AAM_C_GAINA] = (st_r.meas.inPwr > IN_NOM_TH) && (st_r.meas.outputRfPower < OUT_LOW_TH); // RULE2
    cond[`AAM_C_GAINB] = st_r.meas.inPwr > IN_HIGH_TH; // RULE3
    cond[`AAM_C_TEMPW] = st_r.meas.tempInt > TEMP_WARN_TH; // RULE6
    cond[`AAM_C_SUPW]  = outside(st_r.meas.v15, V15_MIN, V15_MAX) || outside(st_r.meas.v5, V5_MIN, V5_MAX) ||
                         outside(st_r.meas.vNeg5, VN5_MIN, VN5_MAX); // RULE7
    cond[`AAM_C_DCW]   = st_r.meas.dcPwr > (mode2 ? DCW_M2 : DCW_M1); // RULE8
    cond[`AAM_C_TEMPS] = st_r.meas.tempBase > TEMP_SHUT_TH; // RULE12
    cond[`AAM_C_HVS]   = mode2 ? outside(st_r.meas.vHigh, VHI2_MIN, VHI2_MAX)
                               : outside(st_r.meas.vHigh, VHI1_MIN, VHI1_MAX); // RULE13
    cond[`AAM_C_V9S]   = outside(st_r.meas.v9, V9_MIN, V9_MAX); // RULE14
    cond[`AAM_C_DCS]   = st_r.meas.dcPwr > (mode2 ? DCS_M2 : DCS_M1); // RULE15
    cond[`AAM_C_LOOP1] = st_r.meas.loop1Err > LOOP1_TH; // RULE16
    cond[`AAM_C_LOOP2] = st_r.meas.loop2Err > LOOP2_TH; // RULE17
  end

  // ==========================================================================
  // Persistence timers.
  // ==========================================================================
  for (genvar i = 0; i < NC; i++) begin : g_pers
    aam_persist #(
      .COUNT (PCNT[i])
    ) u_pers (
      .clock (clock),
      .srst  (srst),
      .cond  (cond[i]),
      .hit   (hit[i])
    );
  end

  // ==========================================================================
  // Partial amplifier failure check.
  // ==========================================================================
  aam_att_check #(
    .MARGIN (ATT_MARGIN)
  ) u_att (
    .clock          (clock),
    .srst           (srst),
    .active         (st_r.mainOn && st_r.errOn && loopsConverged),
    .mainAttSetting (st_r.meas.mainAttSetting),
    .errAttSetting  (st_r.meas.errAttSetting),
    .mainAttDefault (st_r.meas.mainAttDefault),
    .errAttDefault  (st_r.meas.errAttDefault),
    .fail           (attFail)
  );

  // ==========================================================================
  // Alarm conditions, latches and amplifier control.
  // ==========================================================================
  always_comb begin
    loop1Above = cond[`AAM_C_LOOP1];
    loop2Above = cond[`AAM_C_LOOP2];
    clrAll     = cmd.enable || cmd.clearAlarms || cmd.disableAmp;

    minCond.gain       = hit[`AAM_C_GAINA] || hit[`AAM_C_GAINB]; // RULE2 RULE3
    minCond.partFail   = attFail; // RULE4 RULE5
    minCond.tempWarn   = hit[`AAM_C_TEMPW]; // RULE6
    minCond.supplyWarn = hit[`AAM_C_SUPW]; // RULE7
    minCond.dcWarn     = hit[`AAM_C_DCW]; // RULE8
    // Right after enable the loop alarm follows the raw error until that error first drops to or below its threshold.
    minCond.loop1      = st_r.loop1Init ? loop1Above : hit[`AAM_C_LOOP1]; // RULE16
    minCond.loop2      = (st_r.loop2Init ? loop2Above : hit[`AAM_C_LOOP2]) ||
                         (pilotLost && st_r.errOn); // RULE1 RULE17
    majCond.tempShut   = hit[`AAM_C_TEMPS]; // RULE12
    majCond.supplyShut = hit[`AAM_C_HVS] || hit[`AAM_C_V9S]; // RULE13 RULE14
    majCond.dcShut     = hit[`AAM_C_DCS]; // RULE15

    st_nxt      = st_r;
    st_nxt.meas = meas; // RULE21

    // A condition present in the clearing cycle wins over the clear.
    st_nxt.minor = ((clrAll || cmd.statusSent) ? '0 : st_r.minor) | minCond; // RULE18 RULE19
    st_nxt.major = (clrAll ? '0 : st_r.major) | majCond; // RULE9 RULE10

    if (cmd.disableAmp) begin
      st_nxt.ampOn = 1'b0;
    end else if (cmd.enable) begin
      st_nxt.ampOn = 1'b1;
    end
    if (st_nxt.ampOn && !st_r.ampOn) begin
      st_nxt.loop1Init = 1'b1;
      st_nxt.loop2Init = 1'b1;
    end else if (!st_nxt.ampOn) begin
      st_nxt.loop1Init = 1'b0;
      st_nxt.loop2Init = 1'b0;
    end else begin
      st_nxt.loop1Init = st_r.loop1Init && loop1Above;
      st_nxt.loop2Init = st_r.loop2Init && loop2Above;
    end

    st_nxt.standby = st_nxt.ampOn && (st_nxt.major != '0); // RULE11
    st_nxt.mainOn  = st_nxt.ampOn && (st_nxt.major == '0); // RULE11
    st_nxt.errOn   = st_nxt.ampOn && (st_nxt.major == '0); // RULE11
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign minorAlarms = st_r.minor;
  assign majorAlarms = st_r.major;
  assign mainAmpOn   = st_r.mainOn;
  assign errAmpOn    = st_r.errOn;
  assign standby     = st_r.standby;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  a_major_standby: assert property (@(posedge clock) disable iff (srst) // RULE11
    (majorAlarms != '0) |-> (!mainAmpOn && !errAmpOn && (standby == st_r.ampOn)))
    else $error("major alarm without standby");
  a_major_sticky: assert property (@(posedge clock) disable iff (srst) // RULE9
    (majorAlarms != '0 && !clrAll) |=> ((majorAlarms & $past(majorAlarms)) == $past(majorAlarms)))
    else $error("major alarm lost without clear");
  a_major_clear: assert property (@(posedge clock) disable iff (srst) // RULE10
    (clrAll && majCond == '0) |=> (majorAlarms == '0))
    else $error("major alarms not cleared");
  a_minor_clear: assert property (@(posedge clock) disable iff (srst) // RULE19
    (clrAll && minCond == '0) |=> (minorAlarms == '0))
    else $error("minor alarms not cleared");
  a_minor_sent: assert property (@(posedge clock) disable iff (srst) // RULE18
    cmd.statusSent |=> (minorAlarms == $past(minCond)))
    else $error("minor alarms wrong after status sent");
  a_gain_cause: assert property (@(posedge clock) disable iff (srst) // RULE2
    $rose(minorAlarms.gain) |-> $past(hit[`AAM_C_GAINA] || hit[`AAM_C_GAINB]))
    else $error("gain alarm without persistent cause");
  a_pilot_loop: assert property (@(posedge clock) disable iff (srst) // RULE1
    (pilotLost && errAmpOn) |=> minorAlarms.loop2)
    else $error("pilot loss did not raise error loop alarm");
  a_dc_shutdown: assert property (@(posedge clock) disable iff (srst) // RULE15
    hit[`AAM_C_DCS] |=> (majorAlarms.dcShut && !mainAmpOn) ##1 !mainAmpOn)
    else $error("dc power shutdown not latched");
  a_loop_first: assert property (@(posedge clock) disable iff (srst) // RULE16
    (st_r.loop1Init && loop1Above) |=> minorAlarms.loop1)
    else $error("first loop alarm missing after enable");

  // ==========================================================================
  // Per-condition latch checks.
  // ==========================================================================
  a_gain_low: assert property (@(posedge clock) disable iff (srst) // RULE2
    hit[`AAM_C_GAINA]
    |=> minorAlarms.gain)
    else $error("low gain missed");
  a_gain_high: assert property (@(posedge clock) disable iff (srst) // RULE3
    hit[`AAM_C_GAINB]
    |=> minorAlarms.gain)
    else $error("high gain missed");
  a_temp_warn: assert property (@(posedge clock) disable iff (srst) // RULE6
    hit[`AAM_C_TEMPW]
    |=> minorAlarms.tempWarn)
    else $error("temp warning missed");
  a_supply_warn: assert property (@(posedge clock) disable iff (srst) // RULE7
    hit[`AAM_C_SUPW]
    |=> minorAlarms.supplyWarn)
    else $error("supply warning missed");
  a_dc_warn: assert property (@(posedge clock) disable iff (srst) // RULE8
    hit[`AAM_C_DCW]
    |=> minorAlarms.dcWarn)
    else $error("dc warning missed");
  a_temp_shut: assert property (@(posedge clock) disable iff (srst) // RULE12
    hit[`AAM_C_TEMPS]
    |=> majorAlarms.tempShut)
    else $error("temp shutdown missed");
  a_rail_shut: assert property (@(posedge clock) disable iff (srst) // RULE13
    hit[`AAM_C_HVS]
    |=> majorAlarms.supplyShut)
    else $error("high rail shutdown missed");
  a_nine_volt: assert property (@(posedge clock) disable iff (srst) // RULE14
    hit[`AAM_C_V9S]
    |=> majorAlarms.supplyShut)
    else $error("9V shutdown missed");
  a_loop1_persist: assert property (@(posedge clock) disable iff (srst) // RULE16
    (!st_r.loop1Init && hit[`AAM_C_LOOP1])
    |=> minorAlarms.loop1)
    else $error("loop1 alarm missed");
  a_loop2_persist: assert property (@(posedge clock) disable iff (srst) // RULE17
    (!st_r.loop2Init && hit[`AAM_C_LOOP2])
    |=> minorAlarms.loop2)
    else $error("loop2 alarm missed");
  a_part_fail: assert property (@(posedge clock) disable iff (srst) // RULE4 RULE5
    attFail
    |=> minorAlarms.partFail)
    else $error("partial failure missed");
  a_minor_keep: assert property (@(posedge clock) disable iff (srst) // RULE18
    (!clrAll && !cmd.statusSent)
    |=> ((minorAlarms & $past(minorAlarms)) == $past(minorAlarms)))
    else $error("minor alarm lost");
  a_standby_off: assert property (@(posedge clock) disable iff (srst) // RULE11
    standby
    |-> (!mainAmpOn && !errAmpOn))
    else $error("amplifier on in standby");
  a_amp_off: assert property (@(posedge clock) disable iff (srst) // RULE10
    cmd.disableAmp
    |=> (!mainAmpOn && !errAmpOn && !standby))
    else $error("disable ignored");
  a_dc_cause: assert property (@(posedge clock) disable iff (srst) // RULE15
    $rose(majorAlarms.dcShut)
    |-> $past(hit[`AAM_C_DCS]))
    else $error("dc shutdown without cause");
endmodule

// ### verif/aam_host_model.sv
// Host station model that pulses commands and polls the alarm status.
module aam_host_model (
  // Clock.
  input  wire logic               clock,
  // Alarm status from the monitor.
  input  wire aam_pkg::aam_minor_t minorAlarms,
  input  wire aam_pkg::aam_major_t majorAlarms,
  // Commands to the monitor.
  output aam_pkg::aam_cmd_t        cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  import aam_pkg::*;

  logic [9:0] lastReport;

  initial begin
    cmd = '0;
    lastReport = '0;
  end

  // ==========================================================================
  // Command pulse.
  // A command stands for exactly one cycle; a poll keeps the status seen at the edge that takes it.
  task automatic send(input aam_cmd_t c);
    @(posedge clock);
    cmd <= c;
    @(posedge clock);
    if (c.statusSent) begin
      lastReport = {minorAlarms, majorAlarms};
    end
    cmd <= '0;
  endtask
endmodule

// ### verif/testbench.sv
// Self-checking testbench for the amplifier alarm monitor.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import aam_pkg::*;

  localparam int unsigned PN = 20;
  localparam int unsigned DN = 8;
  localparam int unsigned LN = 40;
  localparam int B_GAIN = 9;
  localparam int B_PART = 8;
  localparam int B_TW = 7;
  localparam int B_SW = 6;
  localparam int B_DW = 5;
  localparam int B_L1 = 4;
  localparam int B_L2 = 3;
  localparam int B_TS = 2;
  localparam int B_SS = 1;
  localparam int B_DS = 0;
  localparam aam_cmd_t C_EN = 4'h8;
  localparam aam_cmd_t C_CLR = 4'h4;
  localparam aam_cmd_t C_DIS = 4'h2;
  localparam aam_cmd_t C_POLL = 4'h1;

  logic       clock;
  logic       srst;
  logic       mode2;
  logic       loopsConverged;
  logic       pilotLost;
  aam_meas_t  meas;
  aam_meas_t  nom;
  aam_meas_t  m;
  aam_cmd_t   cmd;
  aam_minor_t minorAlarms;
  aam_major_t majorAlarms;
  logic       mainAmpOn;
  logic       errAmpOn;
  logic       standby;
  int         num_errors;
  int         check_count;
  wire logic [9:0] st = {minorAlarms, majorAlarms};
  wire logic [2:0] amp = {mainAmpOn, errAmpOn, standby};

  aam_monitor #(.PERSIST_CYC(PN), .DCSHUT_CYC(DN), .LOOP_CYC(LN)) aam_monitor_i (
    .clock(clock), .srst(srst), .meas(meas), .mode2(mode2), .loopsConverged(loopsConverged),
    .pilotLost(pilotLost), .cmd(cmd), .minorAlarms(minorAlarms), .majorAlarms(majorAlarms),
    .mainAmpOn(mainAmpOn), .errAmpOn(errAmpOn), .standby(standby));

  aam_host_model aam_host_model_i (
    .clock(clock), .minorAlarms(minorAlarms), .majorAlarms(majorAlarms), .cmd(cmd));

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t ns: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic drive(input aam_meas_t v);
    @(posedge clock);
    meas <= v;
  endtask

  task automatic hostSend(input aam_cmd_t c);
    aam_host_model_i.send(c);
    cyc(1);
  endtask

  // The alarm must be absent one cycle before its persistence plus pipeline ends, and present after it.
  task automatic watch(input int b, input int n);
    cyc(n + 2);
    check(10'(st[b]), 10'h000, "early alarm");
    cyc(1);
    check(10'(st[b]), 10'h001, "late alarm");
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic fault(input aam_meas_t v, input int b, input int n, input bit major);
    drive(v);
    watch(b, n);
    drive(nom);
    cyc(3);
    hostSend(C_POLL);
    check(10'(aam_host_model_i.lastReport[b]), 10'h001, "report");
    check(10'(st[b]), 10'(major), "after poll");
    if (major) begin
      check(10'(amp), 10'h001, "standby");
      hostSend(C_CLR);
      check(10'(st[b]), 10'h000, "major clear");
      check(10'(amp), 10'h006, "restart");
    end
  endtask

  task automatic minorStays();
    m = nom;
    m.inPwr = 16'h001E;
    fault(m, B_GAIN, PN, 1'b0);
    drive(m);
    watch(B_GAIN, PN);
    hostSend(C_POLL);
    check(10'(st[B_GAIN]), 10'h001, "condition present");
    drive(nom);
    cyc(3);
    hostSend(C_DIS);
    check(st, 10'h000, "disable clears");
    check(10'(amp), 10'h000, "disabled");
    hostSend(C_EN);
    check(10'(amp), 10'h006, "enabled");
  endtask

  task automatic loops();
    m = nom;
    m.loop1Err = 16'h09C5;
    m.loop2Err = 16'h07D1;
    hostSend(C_DIS);
    drive(m);
    hostSend(C_EN);
    cyc(2);
    check(10'(st[B_L1]), 10'h001, "loop1 at enable");
    check(10'(st[B_L2]), 10'h001, "loop2 at enable");
    drive(nom);
    cyc(3);
    hostSend(C_CLR);
    check(st, 10'h000, "loops cleared");
    drive(m);
    watch(B_L1, LN);
    check(10'(st[B_L2]), 10'h001, "loop2 persisted");
    drive(nom);
    @(posedge clock);
    pilotLost <= 1'b1;
    cyc(3);
    hostSend(C_CLR);
    check(10'(st[B_L2]), 10'h001, "pilot loss");
    @(posedge clock);
    pilotLost <= 1'b0;
    cyc(3);
    hostSend(C_CLR);
    check(st, 10'h000, "pilot cleared");
  endtask

  task automatic partFail();
    m = nom;
    m.mainAttSetting = 16'h0050;
    drive(m);
    @(posedge clock);
    loopsConverged <= 1'b1;
    cyc(4);
    check(10'(st[B_PART]), 10'h001, "initial compare");
    @(posedge clock);
    loopsConverged <= 1'b0;
    drive(nom);
    cyc(3);
    hostSend(C_CLR);
    @(posedge clock);
    loopsConverged <= 1'b1;
    cyc(4);
    check(10'(st[B_PART]), 10'h000, "good baseline");
    m = nom;
    m.errAttSetting = 16'h0053;
    drive(m);
    cyc(4);
    check(10'(st[B_PART]), 10'h001, "tracking drop");
    @(posedge clock);
    loopsConverged <= 1'b0;
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (6000) @(posedge clock);
    num_errors++;
    finish_test();
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    nom = '0;
    nom.outputRfPower = 16'h012C;
    nom.tempInt = 16'h0019;
    nom.tempBase = 16'h0019;
    nom.v15 = 16'h3A98;
    nom.v5 = 16'h1388;
    nom.vNeg5 = 16'hEC78;
    nom.vHigh = 16'h61A8;
    nom.v9 = 16'h2328;
    nom.dcPwr = 16'h00C8;
    nom.mainAttSetting = 16'h0064;
    nom.errAttSetting = 16'h0064;
    nom.mainAttDefault = 16'h0064;
    nom.errAttDefault = 16'h0064;
    meas = nom;
    srst = 1'b1;
    mode2 = 1'b0;
    loopsConverged = 1'b0;
    pilotLost = 1'b0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    cyc(1);
    check(st, 10'h000, "reset");
    check(10'(amp), 10'h000, "reset amps");
    hostSend(C_EN);
    check(10'(amp), 10'h006, "enable");
    m = nom;
    m.inPwr = 16'hFFE2;
    m.outputRfPower = 16'h00F0;
    fault(m, B_GAIN, PN, 1'b0);
    minorStays();
    m = nom;
    m.tempInt = 16'h005B;
    drive(m);
    cyc(PN - 2);
    drive(nom);
    fault(m, B_TW, PN, 1'b0);
    m = nom;
    m.v15 = 16'h4075;
    fault(m, B_SW, PN, 1'b0);
    m = nom;
    m.v5 = 16'h1193;
    fault(m, B_SW, PN, 1'b0);
    m = nom;
    m.vNeg5 = 16'hEA83;
    fault(m, B_SW, PN, 1'b0);
    m = nom;
    m.tempBase = 16'h0060;
    fault(m, B_TS, PN, 1'b1);
    m = nom;
    m.vHigh = 16'h7851;
    fault(m, B_SS, PN, 1'b1);
    m = nom;
    m.v9 = 16'h1FA3;
    fault(m, B_SS, PN, 1'b1);
    m = nom;
    m.dcPwr = 16'h0178;
    fault(m, B_DW, PN, 1'b0);
    m.dcPwr = 16'h01A2;
    fault(m, B_DS, DN, 1'b1);
    @(posedge clock);
    mode2 <= 1'b1;
    m = nom;
    m.vHigh = 16'h6497;
    fault(m, B_SS, PN, 1'b1);
    m = nom;
    m.dcPwr = 16'h012D;
    fault(m, B_DW, PN, 1'b0);
    m.dcPwr = 16'h014B;
    fault(m, B_DS, DN, 1'b1);
    @(posedge clock);
    mode2 <= 1'b0;
    loops();
    partFail();
    cyc(2);
    finish_test();
  end
endmodule
